// ### hdl/port_io_crossbar_assign.v
// priority port crossbar with per-pin mode control and AXI4-Lite registers
//
// Function
// - SMBus, UART, CAN, LIN each claim both pins
// - UART transmit/receive fixed on pins 4,5
// - CAN transmit/receive fixed on pins 6,7
// - unclaimed pins remain general-purpose port I/O
// - slave select routed only in four-wire mode
// - analog pin: no pull-up, driver, receiver
// - input mode 1 digital, 0 analog; reset digital
// - output mode bit picks open-drain or push-pull
// - SMBus pins always open-drain when assigned
// - pull-ups on open-drain pins unless disabled
// - pull-up off while pin drives low
// - routing only once crossbar enabled
// - all drivers off while crossbar disabled
// - digital-mode pins still usable by analog
// - port 4 is digital only
// - lowest free unskipped pin per signal, priority
// - skipped pins treated as already assigned
`timescale 1ns/1ps
`default_nettype none
`include "xbar_defines.vh"
module port_io_crossbar_assign (
    input wire CLK,
    input wire RST,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire [25:0] PERIPH_OUT,
    input wire [25:0] PERIPH_OE,
    output reg [25:0] PERIPH_IN,
    input wire [32:0] PIN_IN,
    output reg [32:0] PIN_OUT,
    output reg [32:0] PIN_OE,
    output reg [32:0] PIN_PULLUP,
    output reg [32:0] PIN_RX_EN
);
    reg [7:0] sel_a_reg;
    reg [7:0] sel_b_reg;
    reg [7:0] sel_c_reg;
    reg [7:0] spi_ctl_reg;
    reg [32:0] mdin_reg;
    reg [32:0] mdout_reg;
    reg [32:0] skip_reg;
    reg [32:0] latch_reg;
    reg [32:0] claim_reg;
    reg [5:0] aw_idx_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;

    wire [32:0] pin_state;
    wire xbar_en;
    wire pud;
    wire four_wire;
    wire [2:0] pca_cnt;
    wire wr_go;
    wire [32:0] mdin_eff;

    reg [25:0] sig_en;
    reg [32:0] taken;
    reg [32:0] own_v;
    reg [4:0] own_s [0:32];
    reg [5:0] sig_pin [0:25];
    reg [25:0] sig_has;
    reg [5:0] f;
    reg [32:0] out_next;
    reg [32:0] oe_next;
    reg [32:0] pu_next;
    reg [32:0] rx_next;
    reg [25:0] pin_in_next;
    reg analog;
    reg od;
    reg val;
    reg drv;
    reg [31:0] rd_word;
    reg rd_ok;
    integer s;
    integer p;
    integer k;
    integer m;
    integer j;

    function [31:0] apply_strb;
        input [31:0] old;
        input [31:0] wd;
        input [3:0] st;
        integer b;
        begin
            apply_strb = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (st[b]) begin
                    apply_strb[b*8 +: 8] = wd[b*8 +: 8];
                end
            end
        end
    endfunction

    // lowest pin not yet taken, NO_PIN when the port is full
    function [5:0] first_free;
        input [32:0] t;
        integer i;
        begin
            first_free = `NO_PIN;
            for (i = `NPIN - 1; i >= 0; i = i - 1) begin
                if (!t[i]) begin
                    first_free = i[5:0];
                end
            end
        end
    endfunction

    pin_input_filter #(
        .W(`NPIN)
    ) u_filter (
        .clk(CLK),
        .rst(RST),
        .d(PIN_IN),
        .q(pin_state)
    );

    assign xbar_en = sel_c_reg[`C_XBAR_EN];
    assign pud = sel_c_reg[`C_PUD];
    assign four_wire = spi_ctl_reg[`SPI_SSMODE_LO +: 2] != 2'b00;
    assign pca_cnt = sel_b_reg[`B_PCA_LO +: 3];
    // port 4 has no analog mode
    assign mdin_eff = mdin_reg | (33'h1 << `DIG_ONLY_PIN);

    // signal enables in priority order
    always @* begin
        sig_en = 26'h0;
        sig_en[`S_UTX +: 2] = {2{sel_a_reg[`A_UART]}};
        sig_en[`S_CTX +: 2] = {2{sel_a_reg[`A_CAN]}};
        sig_en[`S_SCK +: 3] = {3{sel_a_reg[`A_SPI]}};
        sig_en[`S_NSS] = sel_a_reg[`A_SPI] & four_wire;
        sig_en[`S_SDA +: 2] = {2{sel_a_reg[`A_SMB]}};
        sig_en[`S_CP0 +: 4] = sel_a_reg[`A_CP1A:`A_CP0];
        sig_en[`S_SYSCK] = sel_b_reg[`B_SYSCK];
        for (k = 0; k < 6; k = k + 1) begin
            // code 7 is reserved and routes no module
            sig_en[`S_CEX0 + k] = (pca_cnt != 3'h7) && (pca_cnt > k);
        end
        sig_en[`S_ECI +: 3] = sel_b_reg[`B_T1:`B_ECI];
        sig_en[`S_LIN_TX +: 2] = {2{sel_c_reg[`C_LIN]}};
    end

    // pure function of present settings, no history kept
    always @* begin
        taken = skip_reg;
        own_v = 33'h0;
        sig_has = 26'h0;
        f = `NO_PIN;
        for (s = 0; s < `NSIG; s = s + 1) begin
            sig_pin[s] = `NO_PIN;
        end
        for (p = 0; p < `NPIN; p = p + 1) begin
            own_s[p] = 5'h00;
        end
        // fixed pins override skip bits
        for (s = 0; s < `N_FIXED; s = s + 1) begin
            if (sig_en[s]) begin
                sig_has[s] = 1'b1;
                sig_pin[s] = s[5:0] + `FIXED_BASE;
                taken[s + `FIXED_BASE] = 1'b1;
            end
        end
        for (s = `N_FIXED; s < `NSIG; s = s + 1) begin
            if (sig_en[s]) begin
                f = first_free(taken);
                if (f != `NO_PIN) begin
                    sig_has[s] = 1'b1;
                    sig_pin[s] = f;
                    taken[f] = 1'b1;
                end
            end
        end
        for (s = 0; s < `NSIG; s = s + 1) begin
            if (sig_has[s]) begin
                own_v[sig_pin[s]] = 1'b1;
                own_s[sig_pin[s]] = s[4:0];
            end
        end
    end

    // per-pin driver, pull-up and receiver
    always @* begin
        out_next = 33'h0;
        oe_next = 33'h0;
        pu_next = 33'h0;
        rx_next = 33'h0;
        analog = 1'b0;
        od = 1'b0;
        val = 1'b0;
        drv = 1'b0;
        for (m = 0; m < `NPIN; m = m + 1) begin
            analog = ~mdin_eff[m];
            od = ~mdout_reg[m];
            // unclaimed pins fall back to the port latch
            val = latch_reg[m];
            drv = 1'b1;
            if (xbar_en && own_v[m]) begin
                val = PERIPH_OUT[own_s[m]];
                drv = PERIPH_OE[own_s[m]];
                if (own_s[m] == `S_SDA || own_s[m] == `S_SCL) begin
                    od = 1'b1;
                end
            end
            if (!xbar_en || analog) begin
                oe_next[m] = 1'b0;
            end else if (od) begin
                oe_next[m] = drv & ~val;
            end else begin
                oe_next[m] = drv;
                out_next[m] = val;
            end
            // pull-up dropped while sinking to save supply current
            pu_next[m] = ~pud & od & ~analog
                & ~(oe_next[m] & ~out_next[m]);
            rx_next[m] = ~analog;
        end
    end

    // receiver gate only; analog paths see the pad in either mode
    always @* begin
        pin_in_next = {`NSIG{1'b1}};
        for (j = 0; j < `NSIG; j = j + 1) begin
            if (xbar_en && sig_has[j]) begin
                pin_in_next[j] = pin_state[sig_pin[j]] & mdin_eff[sig_pin[j]];
            end
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            PIN_OUT <= 33'h0;
            PIN_OE <= 33'h0;
            PIN_PULLUP <= 33'h0;
            PIN_RX_EN <= 33'h0;
            PERIPH_IN <= {`NSIG{1'b1}};
            claim_reg <= 33'h0;
        end else begin
            PIN_OUT <= out_next;
            PIN_OE <= oe_next;
            PIN_PULLUP <= pu_next;
            PIN_RX_EN <= rx_next;
            PERIPH_IN <= pin_in_next;
            claim_reg <= xbar_en ? own_v : 33'h0;
        end
    end

    // write channel: address and data taken in either order
    assign wr_go = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;

    always @(posedge CLK) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `RESP_OKAY;
            aw_idx_reg <= 6'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            sel_a_reg <= `RST_SEL;
            sel_b_reg <= `RST_SEL;
            sel_c_reg <= `RST_SEL;
            spi_ctl_reg <= `RST_SPI_CTL;
            mdin_reg <= `RST_MDIN;
            mdout_reg <= `RST_MDOUT;
            skip_reg <= `RST_SKIP;
            latch_reg <= `RST_LATCH;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                S_AXI_AWREADY <= 1'b0;
                aw_idx_reg <= S_AXI_AWADDR[7:2];
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                S_AXI_WREADY <= 1'b0;
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
            if (wr_go) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= `RESP_OKAY;
                case (aw_idx_reg)
                    `OFS_SEL_A: begin
                        if (wstrb_reg[0]) begin
                            sel_a_reg <= wdata_reg[7:0];
                        end
                    end
                    `OFS_SEL_B: begin
                        // bit 0 is reserved and kept at zero
                        if (wstrb_reg[0]) begin
                            sel_b_reg <= wdata_reg[7:0] & 8'hFE;
                        end
                    end
                    `OFS_SEL_C: begin
                        if (wstrb_reg[0]) begin
                            sel_c_reg <= wdata_reg[7:0];
                        end
                    end
                    `OFS_SPI_CTL: begin
                        if (wstrb_reg[0]) begin
                            spi_ctl_reg <= wdata_reg[7:0];
                        end
                    end
                    `OFS_MDIN_LO: begin
                        mdin_reg[31:0] <= apply_strb(mdin_reg[31:0],
                            wdata_reg, wstrb_reg);
                    end
                    `OFS_MDOUT_LO: begin
                        mdout_reg[31:0] <= apply_strb(mdout_reg[31:0],
                            wdata_reg, wstrb_reg);
                    end
                    `OFS_MDOUT_HI: begin
                        if (wstrb_reg[0]) begin
                            mdout_reg[32] <= wdata_reg[0];
                        end
                    end
                    `OFS_SKIP_LO: begin
                        skip_reg[31:0] <= apply_strb(skip_reg[31:0],
                            wdata_reg, wstrb_reg);
                    end
                    `OFS_SKIP_HI: begin
                        if (wstrb_reg[0]) begin
                            skip_reg[32] <= wdata_reg[0];
                        end
                    end
                    `OFS_LATCH_LO: begin
                        latch_reg[31:0] <= apply_strb(latch_reg[31:0],
                            wdata_reg, wstrb_reg);
                    end
                    `OFS_LATCH_HI: begin
                        if (wstrb_reg[0]) begin
                            latch_reg[32] <= wdata_reg[0];
                        end
                    end
                    `OFS_MDIN_HI, `OFS_PINS_LO, `OFS_PINS_HI,
                    `OFS_CLAIM_LO, `OFS_CLAIM_HI: begin
                        // read-only words, write ignored
                        S_AXI_BRESP <= `RESP_OKAY;
                    end
                    default: begin
                        S_AXI_BRESP <= `RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    always @* begin
        rd_ok = 1'b1;
        rd_word = 32'h0;
        case (S_AXI_ARADDR[7:2])
            `OFS_SEL_A: rd_word = {24'h0, sel_a_reg};
            `OFS_SEL_B: rd_word = {24'h0, sel_b_reg};
            `OFS_SEL_C: rd_word = {24'h0, sel_c_reg};
            `OFS_SPI_CTL: rd_word = {24'h0, spi_ctl_reg};
            `OFS_MDIN_LO: rd_word = mdin_eff[31:0];
            `OFS_MDIN_HI: rd_word = {31'h0, mdin_eff[32]};
            `OFS_MDOUT_LO: rd_word = mdout_reg[31:0];
            `OFS_MDOUT_HI: rd_word = {31'h0, mdout_reg[32]};
            `OFS_SKIP_LO: rd_word = skip_reg[31:0];
            `OFS_SKIP_HI: rd_word = {31'h0, skip_reg[32]};
            `OFS_LATCH_LO: rd_word = latch_reg[31:0];
            `OFS_LATCH_HI: rd_word = {31'h0, latch_reg[32]};
            `OFS_PINS_LO: rd_word = pin_state[31:0] & mdin_eff[31:0];
            `OFS_PINS_HI: rd_word = {31'h0, pin_state[32] & mdin_eff[32]};
            `OFS_CLAIM_LO: rd_word = claim_reg[31:0];
            `OFS_CLAIM_HI: rd_word = {31'h0, claim_reg[32]};
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= `RESP_OKAY;
        end else begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_word;
                S_AXI_RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
                S_AXI_ARREADY <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### hdl/xbar_defines.vh
// constants for the port crossbar: offsets, fields, resets, signal order
`ifndef XBAR_DEFINES_VH
`define XBAR_DEFINES_VH

`define NPIN 33
`define NSIG 26

`define OFS_SEL_A 6'h00
`define OFS_SEL_B 6'h01
`define OFS_SEL_C 6'h02
`define OFS_SPI_CTL 6'h03
`define OFS_MDIN_LO 6'h04
`define OFS_MDIN_HI 6'h05
`define OFS_MDOUT_LO 6'h06
`define OFS_MDOUT_HI 6'h07
`define OFS_SKIP_LO 6'h08
`define OFS_SKIP_HI 6'h09
`define OFS_LATCH_LO 6'h0A
`define OFS_LATCH_HI 6'h0B
`define OFS_PINS_LO 6'h0C
`define OFS_PINS_HI 6'h0D
`define OFS_CLAIM_LO 6'h0E
`define OFS_CLAIM_HI 6'h0F

`define RST_SEL 8'h00
`define RST_SPI_CTL 8'h00
`define RST_MDIN 33'h1FFFFFFFF
`define RST_MDOUT 33'h000000000
`define RST_SKIP 33'h000000000
`define RST_LATCH 33'h1FFFFFFFF

`define A_UART 0
`define A_CAN 1
`define A_SPI 2
`define A_SMB 3
`define A_CP0 4
`define A_CP0A 5
`define A_CP1 6
`define A_CP1A 7
`define B_SYSCK 1
`define B_PCA_LO 2
`define B_ECI 5
`define B_T0 6
`define B_T1 7
`define C_LIN 0
`define C_XBAR_EN 6
`define C_PUD 7
`define SPI_SSMODE_LO 2

`define S_UTX 0
`define S_CTX 2
`define S_SCK 4
`define S_NSS 7
`define S_SDA 8
`define S_SCL 9
`define S_CP0 10
`define S_SYSCK 14
`define S_CEX0 15
`define S_ECI 21
`define S_LIN_TX 24
`define S_LIN_RX 25
`define N_FIXED 4
`define FIXED_BASE 6'h04
`define DIG_ONLY_PIN 32
`define NO_PIN 6'h3F
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### hdl/pin_input_filter.v
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_input_filter #(
    parameter W = 33
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    wire [W-1:0] differ;

    // s1 is only seen by s2; s2/s3 must agree before q moves
    assign differ = s2_reg ^ s3_reg;

    always @(posedge clk) begin
        if (rst) begin
            s1_reg <= {W{1'b1}};
            s2_reg <= {W{1'b1}};
            s3_reg <= {W{1'b1}};
            q <= {W{1'b1}};
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q <= (s3_reg & ~differ) | (q & differ);
        end
    end
endmodule
`default_nettype wire

// ### verification/board_pins.sv
// board-side model of the pads around the crossbar
`timescale 1ns/1ps
`default_nettype none
module board_pins (
    input wire logic clk,
    input wire logic [32:0] pin_out,
    input wire logic [32:0] pin_oe,
    input wire logic [32:0] pin_pullup,
    input wire logic [32:0] ext_drive,
    input wire logic [32:0] ext_val,
    output logic [32:0] pin_in
);
    // a floating pad without pull-up wanders instead of holding a level
    logic [32:0] drift = 33'h0AAAAAAAA;
    always @(posedge clk) begin
        drift <= ~drift;
    end
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_val)
        | (~pin_oe & ~ext_drive & (pin_pullup | drift));
endmodule
`default_nettype wire

// ### verification/port_io_crossbar_assign_sva.sv
// port assertions for the crossbar and its register bus
`timescale 1ns/1ps
`default_nettype none
`include "xbar_defines.vh"
module xbar_port_sva (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [25:0] PERIPH_IN,
    input wire logic [32:0] PIN_OUT,
    input wire logic [32:0] PIN_OE,
    input wire logic [32:0] PIN_PULLUP,
    input wire logic [32:0] PIN_RX_EN
);
    logic [5:0] wa;
    logic [31:0] wd;
    logic en;
    // shadow of the enable bit, updated when the write answer appears
    always_ff @(posedge CLK) begin
        if (RST) begin
            wa <= 6'h00;
            wd <= 32'h0;
            en <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) wa <= S_AXI_AWADDR[7:2];
            if (S_AXI_WVALID && S_AXI_WREADY) wd <= S_AXI_WDATA;
            if ($rose(S_AXI_BVALID) && wa == `OFS_SEL_C) en <= wd[`C_XBAR_EN];
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_analog_pin_off: assert property (
        (~PIN_RX_EN & (PIN_PULLUP | PIN_OE)) == 33'h0)
        else $error("analog pin still active");
    a_pullup_low_off: assert property (
        (PIN_OE & ~PIN_OUT & PIN_PULLUP) == 33'h0)
        else $error("pull-up on while driving low");
    a_reset_digital: assert property ($fell(RST) |=> &PIN_RX_EN)
        else $error("pins not digital after reset");
    a_top_pin_digital: assert property (
        !$past(RST) |-> PIN_RX_EN[32])
        else $error("digital-only pin went analog");
    a_drivers_off: assert property (!en |-> PIN_OE == 33'h0)
        else $error("driver on with crossbar off");
    a_inputs_idle: assert property (!en |-> &PERIPH_IN)
        else $error("peripheral input routed with crossbar off");
    a_write_latency: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
        else $error("write answer late or early");
    a_bvalid_hold: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write answer dropped");
    a_write_release: assert property (
        S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY)
        else $error("write channel not released");
    a_read_latency: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read answer not next cycle");
    a_rdata_hold: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read answer changed before taken");
endmodule
bind port_io_crossbar_assign xbar_port_sva i_xbar_port_sva (
    .CLK(CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .PERIPH_IN(PERIPH_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PIN_PULLUP(PIN_PULLUP), .PIN_RX_EN(PIN_RX_EN)
);
`default_nettype wire

// ### verification/port_io_crossbar_assign_tb.sv
// register-bus driven checks of the port crossbar
`timescale 1ns/1ps
`default_nettype none
`include "xbar_defines.vh"
module port_io_crossbar_assign_tb;
    logic clk, rst, awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd;
    logic [7:0] aw, ar;
    logic [31:0] wd, rdt, rd;
    logic [1:0] bresp, rresp, rs;
    logic [25:0] per_out, per_oe, per_in;
    logic [32:0] pi, po, poe, pu, rx, xd, xv;
    logic [31:0] rst_val [0:9];
    int num_errors = 0;
    int check_count = 0;

    port_io_crossbar_assign i_port_io_crossbar_assign (
        .CLK(clk), .RST(rst), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(brd), .S_AXI_ARADDR(ar),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd),
        .PERIPH_OUT(per_out), .PERIPH_OE(per_oe), .PERIPH_IN(per_in),
        .PIN_IN(pi), .PIN_OUT(po), .PIN_OE(poe), .PIN_PULLUP(pu),
        .PIN_RX_EN(rx)
    );
    board_pins i_board_pins (
        .clk(clk), .pin_out(po), .pin_oe(poe), .pin_pullup(pu),
        .ext_drive(xd), .ext_val(xv), .pin_in(pi)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("errors %0d, checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic stall(input int n);
        if (n > 50) begin
            num_errors++;
            print_verdict();
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        aw <= {idx, 2'b00};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
            n++;
            stall(n);
        end while (!bv);
        brd <= 1'b1;
        @(posedge clk);
        rs = bresp;
        brd <= 1'b0;
    endtask

    task automatic rdr(input logic [5:0] idx);
        int n;
        n = 0;
        ar <= {idx, 2'b00};
        arv <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            n++;
            stall(n);
        end while (!rv);
        rrd <= 1'b1;
        @(posedge clk);
        rd = rdt;
        rs = rresp;
        rrd <= 1'b0;
    endtask

    initial begin
        rst <= 1'b1;
        {awv, wv, brd, arv, rrd} <= 5'b0;
        aw <= 8'h00;
        ar <= 8'h00;
        wd <= 32'h0;
        per_out <= 26'h0;
        per_oe <= 26'h0000115;
        // pads 5 and 7 held by the board: 0 and 1
        xd <= 33'h0000000A0;
        xv <= 33'h000000080;
        rst_val = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h1,
            32'h0, 32'h0, 32'h0, 32'h0};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        check(rx, 33'h1FFFFFFFF);
        check(poe, 33'h0);
        check(pu, 33'h1FFFFFFFF);
        check(per_in, 26'h3FFFFFF);
        for (int i = 0; i < 10; i++) begin
            rdr(i[5:0]);
            check({rs, rd}, {`RESP_OKAY, rst_val[i]});
        end
        rdr(6'h10);
        check({rs, rd}, {`RESP_SLVERR, 32'h0});
        wr(6'h10, 32'h1);
        check(rs, `RESP_SLVERR);
        wr(`OFS_SEL_A, 32'h0F);
        tick(2);
        check(poe, 33'h0);
        wr(`OFS_SEL_C, 32'h40);
        tick(2);
        rdr(`OFS_CLAIM_LO);
        check(rd, 32'h1FF);
        check(poe, 33'h059);
        check(pu, 33'h1FFFFFFA6);
        tick(8);
        check({per_in[3], per_in[1]}, 2'b10);
        wr(`OFS_MDOUT_LO, 32'h18);
        per_out <= 26'h0000101;
        tick(3);
        check(poe, 33'h051);
        check(po[4], 1'b1);
        check(pu, 33'h1FFFFFFAE);
        wr(`OFS_SPI_CTL, 32'h04);
        wr(`OFS_SKIP_LO, 32'h8003);
        wr(`OFS_SEL_C, 32'h41);
        tick(2);
        rdr(`OFS_CLAIM_LO);
        check(rd, 32'h3FFC);
        wr(`OFS_LATCH_LO, 32'hFFFF3FFF);
        wr(`OFS_MDIN_LO, 32'hFFFF7FFF);
        tick(2);
        check({poe[15:14], po[14], rx[15], pu[15:14]}, 6'b010000);
        wr(`OFS_MDIN_HI, 32'h0);
        rdr(`OFS_MDIN_HI);
        check({rd, rx[32]}, 33'h3);
        wr(`OFS_SEL_C, 32'hC1);
        tick(2);
        check(pu, 33'h0);
        wr(`OFS_SEL_C, 32'h00);
        tick(8);
        check({poe, per_in}, {33'h0, 26'h3FFFFFF});
        print_verdict();
    end
endmodule
`default_nettype wire
